// File: rxf_params.svh
// Purpose: Constants for the receive address filter and wake-up detector
// Assumes: Included by rxf_top only
// Notes: Offsets are byte addresses of 32-bit words
`ifndef RXF_PARAMS_SVH
`define RXF_PARAMS_SVH
`define RXF_OFS_MAC_CTRL    5'h00
`define RXF_OFS_ADDR_HIGH   5'h04
`define RXF_OFS_ADDR_LOW    5'h08
`define RXF_OFS_HASH_HIGH   5'h0c
`define RXF_OFS_HASH_LOW    5'h10
`define RXF_OFS_WAKE_PORT   5'h14
`define RXF_OFS_WAKE_CSR    5'h18
`define RXF_BIT_PASS_MC     0
`define RXF_BIT_PROMISC     1
`define RXF_BIT_INVERSE     2
`define RXF_BIT_HASH_ONLY   3
`define RXF_BIT_HASH_PERF   4
`define RXF_BIT_WAKE_EN     0
`define RXF_BIT_WAKE_RCVD   1
`define RXF_BIT_IRQ_EN      2
`define RXF_BIT_PME_EN      3
`define RXF_BIT_REDUCED     4
`define RXF_BIT_CMD_EN      0
`define RXF_BIT_CMD_MC      3
`define RXF_RST_WORD        32'h0000_0000
`define RXF_CRC32_INIT      32'hffff_ffff
`define RXF_CRC32_POLY      32'hedb8_8320
`define RXF_CRC16_INIT      16'hffff
`define RXF_CRC16_POLY      16'ha001
`define RXF_DA_BYTES        8'h06
`define RXF_MASK_BYTES      8'h1f
`endif

// File: rxf_pkg.sv
// Purpose: Types for the receive address filter
// Assumes: Nothing
// Notes: Bus handshake states
package rxf_pkg;
    typedef enum logic [0:0] {RXF_BUS_IDLE, RXF_BUS_ACK} rxf_bus_e;
    typedef logic [31:0] rxf_word_t;
endpackage

// File: rxf_top.sv
// Purpose: Destination address filter and wake-up frame detector
// Assumes: Byte stream from MAC receive path on clk, Avalon-MM slave
// Notes: Decision comes two cycles after sixth address byte
`timescale 1ns/100ps
`include "rxf_params.svh"
module rxf_top
    import rxf_pkg::*;
#(
    parameter int NUM_FILT = 4
)(
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_data,
    input  wire logic        rx_sof,
    input  wire logic        rx_eof,
    output logic             decision_valid,
    output logic             frame_accept,
    output logic             wake_irq,
    output logic             power_event_out
);
    // Bit-serial CRC steps, LSB first
    function automatic logic [31:0] crc32_byte(input logic [31:0] c, input logic [7:0] d);
        logic [31:0] r;
        r = c;
        for (int k = 0; k < 8; k++)
        begin
            r = (r[0] ^ d[k]) ? ((r >> 1) ^ `RXF_CRC32_POLY) : (r >> 1);
        end
        return r;
    endfunction

    function automatic logic [15:0] crc16_byte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c;
        for (int k = 0; k < 8; k++)
        begin
            r = (r[0] ^ d[k]) ? ((r >> 1) ^ `RXF_CRC16_POLY) : (r >> 1);
        end
        return r;
    endfunction

    function automatic logic [31:0] be_merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] be);
        logic [31:0] r;
        r = o;
        for (int b = 0; b < 4; b++)
        begin
            if (be[b])
            begin
                r[b*8 +: 8] = n[b*8 +: 8];
            end
        end
        return r;
    endfunction

    rxf_bus_e    bus_q;
    rxf_bus_e    bus_d;
    logic        wait_q;
    logic [31:0] rdata_q;
    logic [31:0] ctrl_q;
    logic [31:0] addr_hi_q;
    logic [31:0] addr_lo_q;
    logic [31:0] hash_hi_q;
    logic [31:0] hash_lo_q;
    logic [31:0] wcsr_q;
    logic [31:0] wf_q [0:7];
    logic [2:0]  wf_ptr_q;
    logic [7:0]  idx_q;
    logic [47:0] da_q;
    logic [31:0] crc32_q;
    logic        da_done_q;
    logic        dec_q;
    logic        acc_q;
    logic        addr_ok_q;
    logic        mc_q;
    logic        irq_q;
    logic        pme_q;
    logic [15:0] crc16_q [0:NUM_FILT-1];

    // Bus decode
    wire         req_w      = avs_read | avs_write;
    wire         done_w     = (bus_q == RXF_BUS_ACK);
    wire         wr_w       = done_w & avs_write;
    wire         rd_w       = done_w & avs_read;
    wire         sel_ctrl   = (avs_address == `RXF_OFS_MAC_CTRL);
    wire         sel_ahi    = (avs_address == `RXF_OFS_ADDR_HIGH);
    wire         sel_alo    = (avs_address == `RXF_OFS_ADDR_LOW);
    wire         sel_hhi    = (avs_address == `RXF_OFS_HASH_HIGH);
    wire         sel_hlo    = (avs_address == `RXF_OFS_HASH_LOW);
    wire         sel_port   = (avs_address == `RXF_OFS_WAKE_PORT);
    wire         sel_wcsr   = (avs_address == `RXF_OFS_WAKE_CSR);
    wire [31:0]  wmerge_w   = be_merge(wf_q[wf_ptr_q], avs_writedata, avs_byteenable);
    wire [31:0]  rmux_w     = sel_ctrl ? {27'h0, ctrl_q[4:0]} :
                              sel_ahi  ? {16'h0, addr_hi_q[15:0]} :
                              sel_alo  ? addr_lo_q :
                              sel_hhi  ? hash_hi_q :
                              sel_hlo  ? hash_lo_q :
                              sel_port ? wf_q[wf_ptr_q] :
                              sel_wcsr ? {27'h0, wcsr_q[4:0]} : 32'h0000_0000;

    // Receive stream position
    wire [7:0]   pos_w      = rx_sof ? 8'h00 : idx_q;
    wire         in_da_w    = rx_valid & (pos_w < `RXF_DA_BYTES);
    wire         da_last_w  = rx_valid & (pos_w == `RXF_DA_BYTES - 8'h01);
    wire [31:0]  crc32_in_w = rx_sof ? `RXF_CRC32_INIT : crc32_q;

    // Address classification
    wire [47:0]  station_w  = {addr_hi_q[15:0], addr_lo_q};
    wire         perf_w     = (da_q == station_w);
    wire         mc_w       = da_q[0];
    wire [5:0]   hidx_w     = crc32_q[31:26];
    wire         hash_w     = hidx_w[5] ? hash_hi_q[hidx_w[4:0]] : hash_lo_q[hidx_w[4:0]];
    wire         f_pass_all_multicast    = ctrl_q[`RXF_BIT_PASS_MC];
    wire         f_promiscuous_sel     = ctrl_q[`RXF_BIT_PROMISC];
    wire         f_inv      = ctrl_q[`RXF_BIT_INVERSE];
    wire         f_ho       = ctrl_q[`RXF_BIT_HASH_ONLY];
    wire         f_hp       = ctrl_q[`RXF_BIT_HASH_PERF];
    wire         uni_ok_w   = (f_ho & f_hp) ? hash_w : perf_w;
    wire         mc_ok_w    = f_pass_all_multicast ? 1'b1 : (f_hp ? hash_w : perf_w);
    wire         pass_w     = f_promiscuous_sel ? 1'b1 :
                              f_inv  ? ~perf_w :
                              (mc_w ? mc_ok_w : uni_ok_w);
    wire         wake_on_w  = wcsr_q[`RXF_BIT_WAKE_EN] | wcsr_q[`RXF_BIT_REDUCED];

    // Wake filter fields
    wire         addr_ok_w  = addr_ok_q;
    wire [NUM_FILT-1:0] hit_w;
    genvar g;
    generate
        for (g = 0; g < NUM_FILT; g++)
        begin : g_filt
            wire [30:0] mask_w = wf_q[g][30:0];
            wire [7:0]  cmd_w  = wf_q[4][g*8 +: 8];
            wire [7:0]  off_w  = wf_q[5][g*8 +: 8];
            wire [15:0] ref_w  = wf_q[6 + g/2][(g%2)*16 +: 16];
            wire [7:0]  rel_w  = pos_w - off_w;
            wire        win_w  = rx_valid & (pos_w >= off_w) & (rel_w < `RXF_MASK_BYTES);
            wire        use_w  = win_w & mask_w[rel_w[4:0]];
            wire [15:0] base_w = rx_sof ? `RXF_CRC16_INIT : crc16_q[g];
            assign hit_w[g] = cmd_w[`RXF_BIT_CMD_EN] & (cmd_w[`RXF_BIT_CMD_MC] == mc_q) &
                              addr_ok_w & (crc16_q[g] == ref_w);
            always_ff @(posedge clk or negedge arst_n)
            begin
                if (!arst_n)
                begin
                    crc16_q[g] <= `RXF_CRC16_INIT;
                end
                else if (use_w)
                begin
                    crc16_q[g] <= crc16_byte(base_w, rx_data);
                end
                else if (rx_sof)
                begin
                    crc16_q[g] <= `RXF_CRC16_INIT;
                end
            end
        end
    endgenerate

    wire         wake_hit_w = rx_eof & wake_on_w & dec_q & (|hit_w);
    wire         clr_rcvd_w = wr_w & sel_wcsr & avs_byteenable[0] & avs_writedata[`RXF_BIT_WAKE_RCVD];
    wire         rcvd_d     = wake_hit_w | (wcsr_q[`RXF_BIT_WAKE_RCVD] & ~clr_rcvd_w);
    wire [31:0]  wcsr_wr_w  = be_merge(wcsr_q, avs_writedata, avs_byteenable);
    wire [31:0]  wcsr_d     = {27'h0, (wr_w & sel_wcsr) ? wcsr_wr_w[4:2] : wcsr_q[4:2],
                               rcvd_d, (wr_w & sel_wcsr) ? wcsr_wr_w[0] : wcsr_q[0]};

    always_comb
    begin
        bus_d = bus_q;
        case (bus_q)
            RXF_BUS_IDLE: bus_d = req_w ? RXF_BUS_ACK : RXF_BUS_IDLE;
            RXF_BUS_ACK:  bus_d = RXF_BUS_IDLE;
            default:      bus_d = RXF_BUS_IDLE;
        endcase
    end

    // Bus handshake
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            bus_q   <= RXF_BUS_IDLE;
            wait_q  <= 1'b1;
            rdata_q <= `RXF_RST_WORD;
        end
        else
        begin
            bus_q   <= bus_d;
            wait_q  <= ~(bus_d == RXF_BUS_ACK);
            rdata_q <= (bus_q == RXF_BUS_IDLE && avs_read) ? rmux_w : rdata_q;
        end
    end

    // Configuration registers
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ctrl_q    <= `RXF_RST_WORD;
            addr_hi_q <= `RXF_RST_WORD;
            addr_lo_q <= `RXF_RST_WORD;
            hash_hi_q <= `RXF_RST_WORD;
            hash_lo_q <= `RXF_RST_WORD;
            wcsr_q    <= `RXF_RST_WORD;
        end
        else
        begin
            if (wr_w & sel_ctrl)
            begin
                ctrl_q <= be_merge(ctrl_q, avs_writedata, avs_byteenable);
            end
            if (wr_w & sel_ahi)
            begin
                addr_hi_q <= be_merge(addr_hi_q, avs_writedata, avs_byteenable);
            end
            if (wr_w & sel_alo)
            begin
                addr_lo_q <= be_merge(addr_lo_q, avs_writedata, avs_byteenable);
            end
            if (wr_w & sel_hhi)
            begin
                hash_hi_q <= be_merge(hash_hi_q, avs_writedata, avs_byteenable);
            end
            if (wr_w & sel_hlo)
            begin
                hash_lo_q <= be_merge(hash_lo_q, avs_writedata, avs_byteenable);
            end
            wcsr_q <= wcsr_d;
        end
    end

    // Wake filter port, pointer steps on each access
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wf_ptr_q <= 3'h0;
            for (int i = 0; i < 8; i++)
            begin
                wf_q[i] <= `RXF_RST_WORD;
            end
        end
        else if ((wr_w | rd_w) & sel_port)
        begin
            wf_ptr_q <= wf_ptr_q + 3'h1;
            if (wr_w)
            begin
                wf_q[wf_ptr_q] <= wmerge_w;
            end
        end
    end

    // Destination address capture and hash CRC
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            idx_q     <= 8'h00;
            da_q      <= 48'h0;
            crc32_q   <= `RXF_CRC32_INIT;
            da_done_q <= 1'b0;
        end
        else
        begin
            if (rx_valid)
            begin
                idx_q <= (pos_w == 8'hff) ? 8'hff : pos_w + 8'h01;
            end
            else if (rx_sof)
            begin
                idx_q <= 8'h00;
            end
            if (in_da_w)
            begin
                da_q[pos_w[2:0]*8 +: 8] <= rx_data;
                crc32_q <= crc32_byte(crc32_in_w, rx_data);
            end
            da_done_q <= da_last_w;
        end
    end

    // Decision hold and outputs
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            dec_q     <= 1'b0;
            acc_q     <= 1'b0;
            addr_ok_q <= 1'b0;
            mc_q      <= 1'b0;
            irq_q     <= 1'b0;
            pme_q     <= 1'b0;
        end
        else
        begin
            if (da_done_q)
            begin
                dec_q     <= 1'b1;
                addr_ok_q <= pass_w;
                mc_q      <= mc_w;
                acc_q     <= pass_w & ~wake_on_w;
            end
            else if (rx_eof | rx_sof)
            begin
                dec_q     <= 1'b0;
                acc_q     <= 1'b0;
                addr_ok_q <= 1'b0;
            end
            irq_q <= rcvd_d & wcsr_d[`RXF_BIT_IRQ_EN];
            pme_q <= rcvd_d & wcsr_d[`RXF_BIT_PME_EN];
        end
    end

    assign avs_readdata    = rdata_q;
    assign avs_waitrequest = wait_q;
    assign decision_valid  = dec_q;
    assign frame_accept    = acc_q;
    assign wake_irq        = irq_q;
    assign power_event_out = pme_q;
endmodule // rxf_top

// File: rxf_chk_properties.sv
// Purpose: Port assertions for rxf_top
// Assumes: Bound to every rxf_top
// Notes: Mode bits tracked from completed writes
`timescale 1ns/100ps
module rxf_chk
#(
    parameter int NUM_FILT = 4
)(
    input wire logic        clk,
    input wire logic        arst_n,
    input wire logic [4:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        rx_valid,
    input wire logic [7:0]  rx_data,
    input wire logic        rx_sof,
    input wire logic        rx_eof,
    input wire logic        decision_valid,
    input wire logic        frame_accept,
    input wire logic        wake_irq,
    input wire logic        power_event_out
);
    default clocking dcb @(posedge clk); endclocking
    default disable iff (!arst_n);
    logic wr_done;
    logic prom_q;
    logic wake_q;
    assign wr_done = avs_write && !avs_waitrequest && avs_byteenable[0];
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            prom_q <= 1'b0;
            wake_q <= 1'b0;
        end
        else if (wr_done && avs_address == 5'h00)
            prom_q <= avs_writedata[1];
        else if (wr_done && avs_address == 5'h18)
            wake_q <= avs_writedata[0] || avs_writedata[4];
    end
    a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("request not answered after one wait");
    a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    a_dec_time: assert property (rx_valid && rx_sof ##1 (rx_valid && !rx_sof)[*5] |-> ##1 !decision_valid ##1 decision_valid)
        else $error("decision not two cycles after address");
    a_dec_hold: assert property (decision_valid && !rx_eof && !rx_sof |=> decision_valid)
        else $error("decision dropped in frame");
    a_dec_drop: assert property (decision_valid && (rx_eof || rx_sof) |=> !decision_valid)
        else $error("decision kept past frame end");
    a_acc_valid: assert property (frame_accept |-> decision_valid)
        else $error("accept without decision");
    a_prom_accept: assert property ($rose(decision_valid) && prom_q && !wake_q |-> frame_accept)
        else $error("promiscuous frame rejected");
    a_wake_block: assert property ($rose(decision_valid) && wake_q |-> !frame_accept)
        else $error("normal accept in wake mode");
    a_irq_cause: assert property ($rose(wake_irq) |-> $past(rx_eof) || $past(avs_write))
        else $error("irq rose without frame end or write");
    c_accept: cover property ($rose(decision_valid) && frame_accept);
    c_irq: cover property ($rose(wake_irq));
    c_event: cover property ($rose(power_event_out));
endmodule // rxf_chk
bind rxf_top rxf_chk #(.NUM_FILT(NUM_FILT)) u_rxf_chk (.clk(clk), .arst_n(arst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_sof(rx_sof), .rx_eof(rx_eof), .decision_valid(decision_valid), .frame_accept(frame_accept),
    .wake_irq(wake_irq), .power_event_out(power_event_out));

// File: rxf_src.sv
// Purpose: Receive byte source model
// Assumes: send is called right after a clock edge
// Notes: Idle data shows the inverted last byte
`timescale 1ns/100ps
module rxf_src
(
    input  wire logic clk,
    output logic      rx_valid,
    output logic [7:0] rx_data,
    output logic      rx_sof,
    output logic      rx_eof
);
    logic [7:0] frame_mem [0:15];
    initial
    begin
        rx_valid = 1'b0;
        rx_data  = 8'h5a;
        rx_sof   = 1'b0;
        rx_eof   = 1'b0;
    end
    task automatic send(input int len);
        for (int i = 0; i < len; i++)
        begin
            @(posedge clk);
            rx_valid <= 1'b1;
            rx_sof   <= (i == 0);
            rx_data  <= frame_mem[i];
        end
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_sof   <= 1'b0;
        rx_data  <= ~frame_mem[len-1];
        rx_eof   <= 1'b1;
        @(posedge clk);
        rx_eof   <= 1'b0;
    endtask
endmodule // rxf_src

// File: rxf_tb.sv
// Purpose: Self-checking bench for rxf_top
// Assumes: rxf_src drives the receive stream
// Notes: CRC expectations computed locally
`timescale 1ns/100ps
module tb;
    localparam logic [47:0] ST = 48'h0a0908070602;
    localparam logic [47:0] SO = 48'h0b0908070602;
    localparam logic [47:0] MC = 48'h112233445501;
    logic clk, arst_n, avs_read, avs_write, avs_waitrequest, rx_valid, rx_sof, rx_eof;
    logic decision_valid, frame_accept, wake_irq, power_event_out, got_dec, got_acc;
    logic [4:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [3:0]  avs_byteenable;
    logic [7:0]  rx_data;
    logic [63:0] tbl;
    logic [31:0] wk [8];
    int          n_mismatch = 0;
    int          samples_checked = 0;
    rxf_top #(.NUM_FILT(4)) u_rxf_top (.clk, .arst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .rx_valid, .rx_data, .rx_sof, .rx_eof,
        .decision_valid, .frame_accept, .wake_irq, .power_event_out);
    rxf_src u_rxf_src (.clk, .rx_valid, .rx_data, .rx_sof, .rx_eof);
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk)
        if (rx_sof === 1'b1)
        begin
            got_dec <= 1'b0;
            got_acc <= 1'b0;
        end
        else if (decision_valid === 1'b1)
        begin
            got_dec <= 1'b1;
            got_acc <= frame_accept;
        end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= w;
        avs_read      <= !w;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 50);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        if (avs_waitrequest !== 1'b0)
        begin
            n_mismatch++;
            print_verdict();
        end
        @(posedge clk);
    endtask
    task automatic rdchk(input logic [4:0] a, input logic [31:0] exp, input string nm);
        bus(1'b0, a, 32'h0);
        chk(nm, exp, rd);
    endtask
    function automatic logic [31:0] crc(input logic [31:0] c0, input logic [31:0] p, input logic [7:0] d);
        logic [31:0] c;
        c = c0;
        for (int b = 0; b < 8; b++)
            c = (c >> 1) ^ ((c[0] ^ d[b]) ? p : 32'h0);
        return c;
    endfunction
    function automatic logic [5:0] hidx(input logic [47:0] da);
        logic [31:0] c;
        c = 32'hffffffff;
        for (int i = 0; i < 6; i++)
            c = crc(c, 32'hedb88320, da[8*i+:8]);
        return c[31:26];
    endfunction
    task automatic frame(input logic [47:0] da, input logic exp, input string nm);
        for (int i = 0; i < 14; i++)
            u_rxf_src.frame_mem[i] = (i < 6) ? da[8*i+:8] : 8'(i);
        u_rxf_src.send(14);
        @(posedge clk);
        chk({nm, " decision"}, 32'h1, {31'h0, got_dec});
        chk(nm, {31'h0, exp}, {31'h0, got_acc});
    endtask
    task automatic t_reset();
        rdchk(5'h00, 32'h0, "control reset");
        rdchk(5'h18, 32'h0, "wake status reset");
        bus(1'b1, 5'h1c, 32'hffffffff);
        rdchk(5'h1c, 32'h0, "unmapped");
        avs_byteenable <= 4'h2;
        bus(1'b1, 5'h10, 32'hffffffff);
        avs_byteenable <= 4'hf;
        rdchk(5'h10, 32'h0000ff00, "byte lane");
        $display("test reset done");
    endtask
    task automatic t_perfect();
        bus(1'b1, 5'h04, {16'h0, ST[47:32]});
        bus(1'b1, 5'h08, ST[31:0]);
        frame(ST, 1'b1, "perfect hit");
        frame(SO, 1'b0, "perfect miss");
        frame(MC, 1'b0, "multicast miss");
        frame('1, 1'b0, "broadcast miss");
        $display("test perfect done");
    endtask
    task automatic t_modes();
        bus(1'b1, 5'h00, 32'h2);
        frame('1, 1'b1, "promisc broadcast");
        bus(1'b1, 5'h00, 32'h4);
        frame(ST, 1'b0, "inverse match");
        frame(ST ^ 48'h100, 1'b1, "inverse other");
        bus(1'b1, 5'h00, 32'h1);
        frame(MC, 1'b1, "mcpass multicast");
        frame(SO, 1'b0, "mcpass unicast");
        $display("test modes done");
    endtask
    task automatic t_hash();
        tbl = 64'h1 << hidx(MC);
        bus(1'b1, 5'h0c, tbl[63:32]);
        bus(1'b1, 5'h10, tbl[31:0]);
        bus(1'b1, 5'h00, 32'h10);
        frame(MC, 1'b1, "hash hit");
        frame(ST, 1'b1, "hash perfect unicast");
        tbl = ~tbl;
        bus(1'b1, 5'h0c, tbl[63:32]);
        bus(1'b1, 5'h10, tbl[31:0]);
        frame(MC, 1'b0, "hash clear");
        bus(1'b1, 5'h00, 32'h18);
        frame(SO, tbl[hidx(SO)], "hash unicast");
        frame(MC, tbl[hidx(MC)], "hash multicast");
        bus(1'b1, 5'h00, 32'h19);
        frame(MC, 1'b1, "mcpass over hash");
        frame(SO, tbl[hidx(SO)], "mcpass hash unicast");
        $display("test hash done");
    endtask
    task automatic t_wake();
        wk = '{32'h1, 32'h0, 32'h0, 32'h0, 32'h1, 32'h0c0c0c0c, crc(32'hffff, 32'ha001, 8'h0c), 32'h0};
        bus(1'b1, 5'h00, 32'h1);
        for (int i = 0; i < 8; i++)
            bus(1'b1, 5'h14, wk[i]);
        rdchk(5'h14, 32'h1, "port wrap");
        bus(1'b1, 5'h18, 32'h5);
        frame(MC, 1'b0, "wake multicast");
        chk("irq multicast", 32'h0, {31'h0, wake_irq});
        frame(ST, 1'b0, "wake unicast");
        chk("irq hit", 32'h1, {31'h0, wake_irq});
        chk("event masked", 32'h0, {31'h0, power_event_out});
        rdchk(5'h18, 32'h7, "wake status");
        bus(1'b1, 5'h18, 32'ha);
        @(posedge clk);
        chk("irq cleared", 32'h0, {31'h0, wake_irq});
        chk("event after clear", 32'h0, {31'h0, power_event_out});
        frame(ST, 1'b1, "normal again");
        bus(1'b1, 5'h18, 32'h18);
        frame(ST, 1'b0, "reduced power");
        chk("event raised", 32'h1, {31'h0, power_event_out});
        $display("test wake done");
    endtask
    initial
    begin
        arst_n = 1'b0;
        avs_address = 5'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hf;
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        t_reset();
        t_perfect();
        t_modes();
        t_hash();
        t_wake();
        print_verdict();
    end
endmodule // tb
